// ===== rbp_cfg.svh
// Constants for the reading burst pacer: counts, periods, reset values.
// Assumes a 20 MHz system clock; times are held in us and converted to cycles.
`ifndef RBP_CFG_SVH
`define RBP_CFG_SVH

// ==========================================================
// Clock
`define RBP_CLK_PERIOD_NS       50

// ==========================================================
// Readings per trigger
`define RBP_COUNT_W             24
`define RBP_COUNT_MIN           24'h000001
`define RBP_COUNT_MAX           24'hFFFFFF
`define RBP_COUNT_RST           24'h000001

// ==========================================================
// Pacing period, 1 us units
`define RBP_PERIOD_W            16
`define RBP_PERIOD_MIN_US       16'h004C
`define RBP_PERIOD_MAX_US       16'hFFFE
`define RBP_PERIOD_RST_US       16'hC350
`define RBP_US_NS               1000
`define RBP_US_CYCLES           (`RBP_US_NS / `RBP_CLK_PERIOD_NS)

// ==========================================================
// Minimum sample period per aperture code, 1 us units
`define RBP_MINP_AP0_US         16'h004C
`define RBP_MINP_AP1_US         16'h0140
`define RBP_MINP_AP2_US         16'h0AF0
`define RBP_MINP_AP3_US         16'h4204
`define RBP_MINP_AP4_US         16'h4F4C

// ==========================================================
// Storage and buffers
`define RBP_STORE_DEPTH_W       24
`define RBP_FIFO_DEPTH          512
`define RBP_FIFO_AW             9
`define RBP_WORD_W              16
`define RBP_OBUF_DEPTH          128
`define RBP_OBUF_AW             7

// ==========================================================
// Characters
`define RBP_CHAR_LF             8'h0A
`define RBP_CHAR_COMMA          8'h2C

`endif

// ===== rbp_pkg.sv
// Types shared by the reading burst pacer modules.
// Constants live in rbp_cfg.svh.
`default_nettype none
package rbp_pkg;

	typedef enum logic [2:0] {
		RBP_AP_10US   = 3'h0,
		RBP_AP_100US  = 3'h1,
		RBP_AP_2M5    = 3'h2,
		RBP_AP_16M7   = 3'h3,
		RBP_AP_20M    = 3'h4,
		RBP_AP_267M   = 3'h5,
		RBP_AP_320M   = 3'h6
	} rbp_aperture_e;

	typedef enum logic [4:0] {
		RBP_ST_IDLE   = 5'b00001,
		RBP_ST_ARMED  = 5'b00010,
		RBP_ST_START  = 5'b00100,
		RBP_ST_BUSY   = 5'b01000,
		RBP_ST_WAIT   = 5'b10000
	} rbp_state_e;

	typedef logic [7:0] rbp_byte_t;

endpackage

`default_nettype wire

// ===== rbp_word_if.sv
// Word stream between the pacer and its reading FIFO.
// Valid and ready handshake; a word moves when both are high.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_cfg.svh"

interface rbp_word_if;
	logic                       valid;
	logic                       ready;
	logic [`RBP_WORD_W-1:0]     data;
	logic                       last;

	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface

`default_nettype wire

// ===== rbp_fifo.sv
// Reading FIFO of 512 words, valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_cfg.svh"

module rbp_fifo (
	input  wire logic  clk_in,
	input  wire logic  reset_in,
	rbp_word_if.snk    wr,
	rbp_word_if.src    rd
);
	// Top bit carries the last-word mark along with its word
	logic [`RBP_WORD_W:0]   mem [0:`RBP_FIFO_DEPTH-1];
	logic [`RBP_FIFO_AW:0]  wptr_r;
	logic [`RBP_FIFO_AW:0]  rptr_r;
	logic                   full;
	logic                   empty;

	assign full     = (wptr_r[`RBP_FIFO_AW] != rptr_r[`RBP_FIFO_AW]) &&
	                  (wptr_r[`RBP_FIFO_AW-1:0] == rptr_r[`RBP_FIFO_AW-1:0]);
	assign empty    = (wptr_r == rptr_r);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem[rptr_r[`RBP_FIFO_AW-1:0]][`RBP_WORD_W-1:0];
	assign rd.last  = mem[rptr_r[`RBP_FIFO_AW-1:0]][`RBP_WORD_W];

	always_ff @(posedge clk_in) begin
		if (wr.valid && !full)
			mem[wptr_r[`RBP_FIFO_AW-1:0]] <= {wr.last, wr.data};
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			wptr_r <= '0;
		else if (wr.valid && !full)
			wptr_r <= wptr_r + 1'b1;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			rptr_r <= '0;
		else if (rd.ready && !empty)
			rptr_r <= rptr_r + 1'b1;
	end
endmodule

`default_nettype wire

// ===== rbp_obuf.sv
// Output buffer of 128 formatted bytes with an end flag per byte.
// Host drains with valid/ready; the writer sees ready low when full.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_cfg.svh"

module rbp_obuf
	import rbp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       wr_valid_in,
	input  wire rbp_byte_t  wr_data_in,
	input  wire logic       wr_last_in,
	output logic            wr_ready_out,
	output logic            rd_valid_out,
	output rbp_byte_t       rd_data_out,
	output logic            rd_last_out,
	input  wire logic       rd_ready_in,
	output logic            empty_out
);
	logic [8:0]             mem [0:`RBP_OBUF_DEPTH-1];
	logic [`RBP_OBUF_AW:0]  wptr_r;
	logic [`RBP_OBUF_AW:0]  rptr_r;
	logic                   full;

	assign full = (wptr_r[`RBP_OBUF_AW] != rptr_r[`RBP_OBUF_AW]) &&
	              (wptr_r[`RBP_OBUF_AW-1:0] == rptr_r[`RBP_OBUF_AW-1:0]);
	assign empty_out    = (wptr_r == rptr_r);
	assign wr_ready_out = !full;
	assign rd_valid_out = !empty_out;
	assign rd_data_out  = mem[rptr_r[`RBP_OBUF_AW-1:0]][7:0];
	assign rd_last_out  = mem[rptr_r[`RBP_OBUF_AW-1:0]][8];

	always_ff @(posedge clk_in) begin
		if (wr_valid_in && !full)
			mem[wptr_r[`RBP_OBUF_AW-1:0]] <= {wr_last_in, wr_data_in};
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			wptr_r <= '0;
		else if (wr_valid_in && !full)
			wptr_r <= wptr_r + 1'b1;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			rptr_r <= '0;
		else if (rd_ready_in && !empty_out)
			rptr_r <= rptr_r + 1'b1;
	end
endmodule

`default_nettype wire

// ===== rbp_pacer.sv
// Reading burst pacer: counts readings per trigger, paces them, and streams
// formatted text to the host through the reading FIFO and output buffer.
// Assumes the converter reports busy and delivers ASCII reading words.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_cfg.svh"

// How it works
// - Readings per trigger range one to 16777215
// - Count above storage flags out-of-memory, streaming allowed
// - Preset forces readings per trigger to one
// - Preset selects idle-driven pacing
// - Pacing matters only when count exceeds one
// - Idle pacing starts next reading when idle
// - Pacing period spans 76 us to 65.534 ms
// - Pacing period resets to 50 ms
// - First reading starts without period wait
// - Period must exceed the selected aperture
// - Minimum period per aperture; slow apertures idle-only
// - In scanning, period spaces multiplexer channels; this design has no scanning or multiplexer
// - Stream read arms and starts on trigger
// - Streaming bypasses storage, count unlimited
// - Last reading of a burst ends with a line feed
// - Commas separate readings, end flag on last
// - Output buffer holds 128 bytes
// - Full buffer stalls output, stays busy
// - FIFO 512 words, one or two per reading
// - Pacing query reports idle or timed
module rbp_pacer
	import rbp_pkg::*;
(
	input  wire logic                       CLK_IN,
	input  wire logic                       RESET_IN,
	input  wire logic                       CFG_WRITE_IN,
	input  wire logic [`RBP_COUNT_W-1:0]    CFG_COUNT_IN,
	input  wire logic                       CFG_PACE_TIMED_IN,
	input  wire logic [`RBP_PERIOD_W-1:0]   CFG_PERIOD_US_IN,
	input  wire logic [2:0]                 CFG_APERTURE_IN,
	input  wire logic                       PRESET_IN,
	input  wire logic [`RBP_STORE_DEPTH_W-1:0] STORE_CAPACITY_IN,
	input  wire logic                       STORE_REQ_IN,
	input  wire logic                       STREAM_REQ_IN,
	input  wire logic                       TRIGGER_IN,
	input  wire logic                       ENGINE_BUSY_IN,
	input  wire logic                       RDG_VALID_IN,
	input  wire logic [`RBP_WORD_W-1:0]     RDG_WORD_IN,
	input  wire logic                       RDG_LAST_WORD_IN,
	output logic                            START_READING_OUT,
	output logic [`RBP_COUNT_W-1:0]         READINGS_PER_TRIGGER_OUT,
	output logic                            PACE_TIMED_OUT,
	output logic [`RBP_PERIOD_W-1:0]        PACING_PERIOD_OUT,
	output logic                            CFG_INVALID_OUT,
	output logic                            OUT_OF_MEMORY_OUT,
	output logic                            OVERFLOW_OUT,
	output logic                            BUSY_OUT,
	output logic                            HOST_VALID_OUT,
	output logic [7:0]                      HOST_DATA_OUT,
	output logic                            HOST_EOI_OUT,
	input  wire logic                       HOST_READY_IN
);
	// ==========================================================
	// Configuration
	localparam int unsigned US_CYC = `RBP_US_CYCLES;

	logic [`RBP_COUNT_W-1:0]  count_r;
	logic                     timed_r;
	logic [`RBP_PERIOD_W-1:0] period_r;
	rbp_aperture_e            aperture_r;

	function automatic logic [`RBP_PERIOD_W-1:0] min_period(input rbp_aperture_e ap);
		case (ap)
			RBP_AP_10US:  min_period = `RBP_MINP_AP0_US;
			RBP_AP_100US: min_period = `RBP_MINP_AP1_US;
			RBP_AP_2M5:   min_period = `RBP_MINP_AP2_US;
			RBP_AP_16M7:  min_period = `RBP_MINP_AP3_US;
			RBP_AP_20M:   min_period = `RBP_MINP_AP4_US;
			default:      min_period = `RBP_MINP_AP0_US;
		endcase
	endfunction

	function automatic logic two_words(input rbp_aperture_e ap);
		two_words = (ap != RBP_AP_10US);
	endfunction

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			count_r    <= `RBP_COUNT_RST;
			timed_r    <= 1'b0;
			period_r   <= `RBP_PERIOD_RST_US;
			aperture_r <= RBP_AP_16M7;
		end else if (PRESET_IN) begin
			count_r <= `RBP_COUNT_MIN;
			timed_r <= 1'b0;
		end else if (CFG_WRITE_IN) begin
			// Zero count clamps to one rather than being refused
			count_r <= (CFG_COUNT_IN == '0) ? `RBP_COUNT_MIN : CFG_COUNT_IN;
			timed_r <= CFG_PACE_TIMED_IN;
			if (CFG_PERIOD_US_IN < `RBP_PERIOD_MIN_US)
				period_r <= `RBP_PERIOD_MIN_US;
			else if (CFG_PERIOD_US_IN > `RBP_PERIOD_MAX_US)
				period_r <= `RBP_PERIOD_MAX_US;
			else
				period_r <= CFG_PERIOD_US_IN;
			aperture_r <= (CFG_APERTURE_IN > 3'h6) ? RBP_AP_320M
			                                       : rbp_aperture_e'(CFG_APERTURE_IN);
		end
	end

	assign READINGS_PER_TRIGGER_OUT = count_r;
	assign PACE_TIMED_OUT           = timed_r;
	assign PACING_PERIOD_OUT        = period_r;

	// Timed pacing needs a period above the aperture; slow apertures idle-only
	always_comb begin
		if (!timed_r)
			CFG_INVALID_OUT = 1'b0;
		else if (aperture_r == RBP_AP_267M || aperture_r == RBP_AP_320M)
			CFG_INVALID_OUT = 1'b1;
		else
			CFG_INVALID_OUT = (period_r < min_period(aperture_r));
	end

	// ==========================================================
	// Out of memory: only stored acquisition is refused
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			OUT_OF_MEMORY_OUT <= 1'b0;
		else if (STORE_REQ_IN)
			OUT_OF_MEMORY_OUT <= (count_r == `RBP_COUNT_MAX) ||
			                     (count_r > STORE_CAPACITY_IN);
		else if (STREAM_REQ_IN)
			OUT_OF_MEMORY_OUT <= 1'b0;
	end

	// ==========================================================
	// Burst sequencer
	rbp_state_e              state_r;
	logic [`RBP_COUNT_W-1:0] left_r;
	logic [4:0]              us_div_r;
	logic                    us_tick;
	logic [`RBP_PERIOD_W-1:0] per_cnt_r;
	logic                    period_done;
	logic                    space_ok;
	logic                    ob_ready;

	assign us_tick     = (us_div_r == 5'(US_CYC - 1));
	assign period_done = (per_cnt_r == '0);
	// Spacing rule only applies within a multi-reading burst in timed pacing
	assign space_ok    = !timed_r || (count_r == `RBP_COUNT_MIN) || period_done;

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			us_div_r <= '0;
		// Restart at each start so the spacing is never short of the period
		else if (us_tick || state_r == RBP_ST_START)
			us_div_r <= '0;
		else
			us_div_r <= us_div_r + 1'b1;
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			per_cnt_r <= '0;
		else if (state_r == RBP_ST_START)
			per_cnt_r <= period_r;
		else if (us_tick && !period_done)
			per_cnt_r <= per_cnt_r - 1'b1;
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_r <= RBP_ST_IDLE;
			left_r  <= '0;
		end else begin
			case (state_r)
				RBP_ST_IDLE: begin
					if (STREAM_REQ_IN)
						state_r <= RBP_ST_ARMED;
				end
				RBP_ST_ARMED: begin
					if (PRESET_IN)
						state_r <= RBP_ST_IDLE;
					else if (TRIGGER_IN) begin
						left_r  <= count_r;
						state_r <= RBP_ST_START;
					end
				end
				RBP_ST_START: begin
					left_r  <= left_r - 1'b1;
					state_r <= RBP_ST_BUSY;
				end
				RBP_ST_BUSY: begin
					if (!ENGINE_BUSY_IN)
						state_r <= (left_r == '0) ? RBP_ST_ARMED : RBP_ST_WAIT;
				end
				RBP_ST_WAIT: begin
					if (space_ok && !ENGINE_BUSY_IN && ob_ready)
						state_r <= RBP_ST_START;
				end
				default: state_r <= RBP_ST_IDLE;
			endcase
		end
	end

	// One-cycle start pulse to the converter
	assign START_READING_OUT = (state_r == RBP_ST_START);

	// ==========================================================
	// Reading FIFO and formatter
	rbp_word_if fifo_in ();
	rbp_word_if fifo_out ();

	assign fifo_in.valid = RDG_VALID_IN;
	assign fifo_in.data  = RDG_WORD_IN;
	assign fifo_in.last  = RDG_LAST_WORD_IN;

	rbp_fifo u_fifo (
		.clk_in   (CLK_IN),
		.reset_in (RESET_IN),
		.wr       (fifo_in),
		.rd       (fifo_out)
	);

	// Sticky until preset; losing readings silently would corrupt the stream
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			OVERFLOW_OUT <= 1'b0;
		else if (RDG_VALID_IN && !fifo_in.ready)
			OVERFLOW_OUT <= 1'b1;
		else if (PRESET_IN)
			OVERFLOW_OUT <= 1'b0;
	end

	// Word holds two ASCII chars, high first; last word of a reading ends it
	logic       ob_empty;
	logic       ob_valid;
	rbp_byte_t  ob_data;
	logic       ob_last;
	logic       hi_sent_r;
	logic       need_sep_r;
	logic       sent_any_r;
	logic [`RBP_COUNT_W-1:0] fmt_left_r;
	logic       word_is_last;
	logic       char_phase;

	assign word_is_last = fifo_out.last || !two_words(aperture_r);
	assign char_phase   = hi_sent_r;

	always_comb begin
		ob_valid        = 1'b0;
		ob_data         = 8'h00;
		ob_last         = 1'b0;
		fifo_out.ready  = 1'b0;
		if (need_sep_r) begin
			ob_valid = 1'b1;
			ob_data  = (fmt_left_r == '0) ? `RBP_CHAR_LF : `RBP_CHAR_COMMA;
			ob_last  = (fmt_left_r == '0);
		end else if (fifo_out.valid) begin
			ob_valid       = 1'b1;
			ob_data        = char_phase ? fifo_out.data[7:0] : fifo_out.data[15:8];
			fifo_out.ready = char_phase && ob_ready;
		end
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			hi_sent_r  <= 1'b0;
			need_sep_r <= 1'b0;
			sent_any_r <= 1'b0;
			fmt_left_r <= '0;
		end else if (state_r == RBP_ST_ARMED && TRIGGER_IN) begin
			fmt_left_r <= count_r;
		end else if (ob_valid && ob_ready) begin
			if (need_sep_r) begin
				need_sep_r <= 1'b0;
			end else begin
				hi_sent_r <= !hi_sent_r;
				sent_any_r <= 1'b1;
				if (char_phase && word_is_last) begin
					need_sep_r <= 1'b1;
					fmt_left_r <= fmt_left_r - 1'b1;
				end
			end
		end
	end

	rbp_obuf u_obuf (
		.clk_in       (CLK_IN),
		.reset_in     (RESET_IN),
		.wr_valid_in  (ob_valid),
		.wr_data_in   (ob_data),
		.wr_last_in   (ob_last),
		.wr_ready_out (ob_ready),
		.rd_valid_out (HOST_VALID_OUT),
		.rd_data_out  (HOST_DATA_OUT),
		.rd_last_out  (HOST_EOI_OUT),
		.rd_ready_in  (HOST_READY_IN),
		.empty_out    (ob_empty)
	);

	// Busy while a burst runs or the 128-byte buffer cannot take more
	assign BUSY_OUT = !ob_ready || (state_r != RBP_ST_IDLE && state_r != RBP_ST_ARMED)
	                  || (!ob_empty && sent_any_r && !ob_ready);
endmodule

`default_nettype wire

// ===== rbp_pacer_chk.sv
// Checker of the burst pacer, watching top-level ports only.
// Assumes one clock domain with asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module rbp_pacer_chk
	import rbp_pkg::*;
(
	input wire logic		CLK_IN,
	input wire logic		RESET_IN,
	input wire logic		CFG_WRITE_IN,
	input wire logic [23:0]	CFG_COUNT_IN,
	input wire logic [2:0]	CFG_APERTURE_IN,
	input wire logic		PRESET_IN,
	input wire logic		STORE_REQ_IN,
	input wire logic		STREAM_REQ_IN,
	input wire logic		START_READING_OUT,
	input wire logic [23:0]	READINGS_PER_TRIGGER_OUT,
	input wire logic		PACE_TIMED_OUT,
	input wire logic [15:0]	PACING_PERIOD_OUT,
	input wire logic		CFG_INVALID_OUT,
	input wire logic		OUT_OF_MEMORY_OUT,
	input wire logic		OVERFLOW_OUT,
	input wire logic		HOST_VALID_OUT,
	input wire logic [7:0]	HOST_DATA_OUT,
	input wire logic		HOST_EOI_OUT,
	input wire logic		HOST_READY_IN
);
	// ==========================================================
	// Aperture shadow, not visible at the ports
	logic [2:0]		ap_r;
	logic [15:0]	minp;
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			ap_r <= 3'h3;
		else if (CFG_WRITE_IN && !PRESET_IN)
			ap_r <= (CFG_APERTURE_IN == 3'h7) ? 3'h6 : CFG_APERTURE_IN;
	end
	// Slow apertures: no period is ever long enough
	always_comb begin
		case (ap_r)
		3'h0: minp = 16'h004C;
		3'h1: minp = 16'h0140;
		3'h2: minp = 16'h0AF0;
		3'h3: minp = 16'h4204;
		3'h4: minp = 16'h4F4C;
		default: minp = 16'hFFFF;
		endcase
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	AST_RESET_DEFAULTS: assert property ($fell(RESET_IN) |->
		READINGS_PER_TRIGGER_OUT == 24'h000001 && !PACE_TIMED_OUT && PACING_PERIOD_OUT == 16'hC350)
		else $error("Defaults wrong after reset");
	AST_PRESET: assert property (PRESET_IN |=>
		READINGS_PER_TRIGGER_OUT == 24'h000001 && !PACE_TIMED_OUT)
		else $error("Preset did not restore count and pacing");
	AST_CFG_COUNT: assert property (CFG_WRITE_IN && !PRESET_IN && CFG_COUNT_IN != 24'h000000 |=>
		READINGS_PER_TRIGGER_OUT == $past(CFG_COUNT_IN))
		else $error("Count not loaded");
	AST_PERIOD_RANGE: assert property (
		PACING_PERIOD_OUT >= 16'h004C && PACING_PERIOD_OUT <= 16'hFFFE)
		else $error("Period out of range");
	AST_CFG_INVALID: assert property (
		CFG_INVALID_OUT == (PACE_TIMED_OUT && PACING_PERIOD_OUT < minp))
		else $error("Invalid flag wrong");
	AST_START_PULSE: assert property (START_READING_OUT |=> !START_READING_OUT)
		else $error("Start longer than one cycle");
	AST_LF_EOI: assert property (HOST_VALID_OUT && HOST_EOI_OUT |-> HOST_DATA_OUT == 8'h0A)
		else $error("End flag not on line feed");
	AST_HOST_HOLD: assert property (HOST_VALID_OUT && !HOST_READY_IN && !PRESET_IN |=>
		HOST_VALID_OUT && $stable(HOST_DATA_OUT) && $stable(HOST_EOI_OUT))
		else $error("Host byte dropped while stalled");
	AST_STREAM_OOM: assert property (STREAM_REQ_IN && !STORE_REQ_IN |=> !OUT_OF_MEMORY_OUT)
		else $error("Stream left memory error");
	AST_OVF_STICKY: assert property (OVERFLOW_OUT && !PRESET_IN |=> OVERFLOW_OUT)
		else $error("Overflow flag lost");

	C_START: cover property (START_READING_OUT);
	C_EOI: cover property (HOST_VALID_OUT && HOST_EOI_OUT && HOST_READY_IN);
	C_OVF: cover property ($rose(OVERFLOW_OUT));
endmodule

bind rbp_pacer rbp_pacer_chk rbp_pacer_chk_i (.*);

`default_nettype wire

// ===== rbp_host_model.sv
// Host controller draining the pacer's byte stream.
// Stall input lets the bench hold it off to fill the buffer.
`timescale 1ns/1ps
`default_nettype none

module rbp_host_model (
	input wire logic		clk_in,
	input wire logic		reset_in,
	input wire logic		stall_in,
	input wire logic		valid_in,
	input wire logic [7:0]	data_in,
	input wire logic		eoi_in,
	output logic			ready_out
);
	logic [8:0]	got_q[$];

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			ready_out <= 1'b0;
		else
			ready_out <= !stall_in;
	end
	// End flag kept beside each byte
	always @(posedge clk_in) begin
		if (!reset_in && valid_in === 1'b1 && ready_out === 1'b1)
			got_q.push_back({eoi_in, data_in});
	end
endmodule

`default_nettype wire

// ===== rbp_pacer_tb_top.sv
// Bench of the burst pacer: config, bursts, stall and overflow.
// Bench acts as converter engine; host model drains the output.
`timescale 1ns/1ps
`default_nettype none

module rbp_pacer_tb_top;
	logic			clk, rst, cfg_wr, cfg_timed, eng_busy, rdg_v, rdg_last, host_stall;
	logic [23:0]	cfg_cnt, store_cap, rpt;
	logic [15:0]	cfg_per, rdg_w, per_o;
	logic [2:0]		cfg_ap;
	logic [3:0]		ctl;
	logic			start, timed_o, inval, oom, ovf, busy, hv, heoi, hrdy;
	logic [7:0]		hd;
	int				n_errors, n_tests, cyc, nrd, trig_at, k, nw;
	int				starts[$];
	logic [15:0]	tbl[7] = '{16'h004C, 16'h0140, 16'h0AF0, 16'h4204, 16'h4F4C, 16'hFFFE, 16'hFFFE};

	rbp_pacer rbp_pacer_i (.CLK_IN(clk), .RESET_IN(rst), .CFG_WRITE_IN(cfg_wr),
		.CFG_COUNT_IN(cfg_cnt), .CFG_PACE_TIMED_IN(cfg_timed), .CFG_PERIOD_US_IN(cfg_per),
		.CFG_APERTURE_IN(cfg_ap), .PRESET_IN(ctl[3]), .STORE_CAPACITY_IN(store_cap),
		.STORE_REQ_IN(ctl[2]), .STREAM_REQ_IN(ctl[1]), .TRIGGER_IN(ctl[0]),
		.ENGINE_BUSY_IN(eng_busy), .RDG_VALID_IN(rdg_v), .RDG_WORD_IN(rdg_w),
		.RDG_LAST_WORD_IN(rdg_last), .START_READING_OUT(start), .READINGS_PER_TRIGGER_OUT(rpt),
		.PACE_TIMED_OUT(timed_o), .PACING_PERIOD_OUT(per_o), .CFG_INVALID_OUT(inval),
		.OUT_OF_MEMORY_OUT(oom), .OVERFLOW_OUT(ovf), .BUSY_OUT(busy), .HOST_VALID_OUT(hv),
		.HOST_DATA_OUT(hd), .HOST_EOI_OUT(heoi), .HOST_READY_IN(hrdy));
	rbp_host_model rbp_host_model_i (.clk_in(clk), .reset_in(rst), .stall_in(host_stall),
		.valid_in(hv), .data_in(hd), .eoi_in(heoi), .ready_out(hrdy));

	// ==========================================================
	// Clock and engine
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// Engine: busy a few cycles per start, then nw words per reading
	initial forever begin
		@(posedge clk);
		if (start === 1'b1) begin
			starts.push_back(cyc);
			eng_busy <= 1'b1;
			repeat (6) @(posedge clk);
			eng_busy <= 1'b0;
			rdg_v <= 1'b1;
			rdg_last <= (nw == 1);
			rdg_w <= {8'h41 + 8'(nrd % 26), 8'h61 + 8'(nrd % 26)};
			nrd++;
			@(posedge clk);
			if (nw == 2) begin
				rdg_last <= 1'b1;
				@(posedge clk);
			end
			rdg_v <= 1'b0;
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi, input string m);
		chk(32'(got >= lo && got <= hi), 32'h1, m);
	endtask
	task automatic cfg(input logic [23:0] c, input logic t, input logic [15:0] p,
		input logic [2:0] a);
		cfg_cnt <= c;
		cfg_timed <= t;
		cfg_per <= p;
		cfg_ap <= a;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pulse(input int b);
		ctl[b] <= 1'b1;
		@(posedge clk);
		ctl <= 4'h0;
		@(posedge clk);
	endtask
	task automatic burst(input int n, input logic stl);
		int base;
		int bpr;
		logic [8:0] e;
		base = nrd;
		bpr = 2 * nw + 1;
		starts.delete();
		rbp_host_model_i.got_q.delete();
		host_stall <= stl;
		pulse(1);
		trig_at = cyc;
		pulse(0);
		if (stl) begin
			repeat (3000) @(posedge clk);
			chk(busy, 1'b1, "busy while full");
			chk(rbp_host_model_i.got_q.size(), 0, "nothing out while stalled");
			host_stall <= 1'b0;
		end
		for (k = 0; k < 9000 && rbp_host_model_i.got_q.size() < bpr * n; k++) @(posedge clk);
		chk(rbp_host_model_i.got_q.size(), bpr * n, "byte count");
		chk(starts.size(), n, "starts per trigger");
		chk_rng(starts[0] - trig_at, 2, 2, "first start");
		for (k = 0; k < bpr * n; k++) begin
			e = (k % bpr == bpr - 1) ? ((k == bpr * n - 1) ? 9'h10A : 9'h02C) :
				{1'b0, ((k % bpr % 2 == 0) ? 8'h41 : 8'h61) + 8'((base + k / bpr) % 26)};
			chk(rbp_host_model_i.got_q[k], e, "stream byte");
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		{cfg_wr, cfg_timed, eng_busy, rdg_v, host_stall, ctl, cfg_ap} = '0;
		{cfg_cnt, cfg_per, rdg_w, cyc, nrd, n_errors, n_tests} = '0;
		rdg_last = 1'b1;
		nw = 1;
		store_cap = 24'h0003E8;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(per_o, 16'hC350, "period default");
		chk(rpt, 24'h000001, "count default");
		cfg(24'h000000, 1'b0, 16'h0000, 3'h0);
		chk(rpt, 24'h000001, "count zero");
		chk(per_o, 16'h004C, "period min");
		cfg(24'hFFFFFF, 1'b1, 16'hFFFF, 3'h1);
		chk(rpt, 24'hFFFFFF, "count max");
		chk(per_o, 16'hFFFE, "period max");
		chk(timed_o, 1'b1, "timed pacing");
		pulse(2);
		chk(oom, 1'b1, "memory error");
		pulse(1);
		chk(oom, 1'b0, "stream clears error");
		for (int a = 0; a < 7; a++) begin
			cfg(24'h000002, 1'b1, tbl[a], 3'(a));
			chk(inval, a > 4, "period at minimum");
			if (a > 0) begin
				cfg(24'h000002, 1'b1, tbl[a] - 16'h0001, 3'(a));
				chk(inval, 1'b1, "period below minimum");
			end
		end
		pulse(3);
		chk(rpt, 24'h000001, "preset count");
		chk(timed_o, 1'b0, "preset pacing");
		cfg(24'h000002, 1'b0, 16'h004C, 3'h0);
		burst(2, 1'b0);
		chk_rng(starts[1] - starts[0], 2, 40, "idle spacing");
		cfg(24'h000003, 1'b1, 16'h004C, 3'h0);
		burst(3, 1'b0);
		chk_rng(starts[2] - starts[1], 1520, 1524, "timed spacing");
		// Two words per reading away from the shortest aperture
		nw = 2;
		cfg(24'h000002, 1'b0, 16'h004C, 3'h1);
		burst(2, 1'b0);
		nw = 1;
		cfg(24'h00003C, 1'b0, 16'h004C, 3'h0);
		burst(60, 1'b1);
		host_stall <= 1'b1;
		rdg_v <= 1'b1;
		repeat (700) @(posedge clk);
		rdg_v <= 1'b0;
		@(posedge clk);
		chk(ovf, 1'b1, "overflow set");
		pulse(3);
		chk(ovf, 1'b0, "overflow cleared");
		print_verdict();
	end

	// Whole run is near 7000 cycles
	initial begin
		#2000000;
		n_errors++;
		print_verdict();
	end
endmodule

`default_nettype wire
